// ==== rtl/ods_pkg.sv ====
/*
  Shared constants and types of the octal DDR switch sequencer: register map,
  SPI timing, table layout and state encodings.
  Assumes a 50 MHz system clock and a single-SPI flash on the far side.
*/
package ods_pkg;

  // ==========================================================================
  // Clock and SPI timing
  // ==========================================================================
  localparam int CLK_NS = 20;                  // System clock period
  localparam int SCK_HALF_NS = 40;             // Least half period of SCK
  localparam int CS_HIGH_NS = 50;              // Least chip select high time
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] SCK_DIV_LAST = 2'(SCK_HALF_CYC - 1);
  localparam logic [1:0] CS_GAP_LAST = 2'(CS_HIGH_CYC - 1);

  // ==========================================================================
  // Parameter table layout
  // ==========================================================================
  localparam logic [7:0] CMD_READ_TABLE = 8'h5a;  // Parameter read command
  localparam logic [7:0] ID_LSB = 8'h0a;          // Header word 0, bits 7:0
  localparam logic [7:0] ID_MSB = 8'hff;          // Header word 1, bits 31:24
  localparam int LEN_MSB = 31;                    // Table length field
  localparam int LEN_LSB = 24;
  localparam int PTR_MSB = 23;                    // table_start_pointer field
  localparam int REV_MAJ_LSB = 16;                // Major revision, bits 23:16
  localparam int REV_MIN_LSB = 8;                 // Minor revision, bits 15:8
  localparam logic [5:0] RD_PREFIX = 6'h05;       // Command, 3 address, dummy
  localparam logic [5:0] HDR_BYTES = 6'h0d;       // Prefix plus 8 header bytes
  localparam int TBL_WORDS = 8;                   // Four sequences, two words
  localparam logic [7:0] SEQ_MAX = 8'h07;         // Longest sequence

  // ==========================================================================
  // Register map, byte offsets on the APB side
  // ==========================================================================
  localparam logic [7:0] REG_CTRL = 8'h00;     // 0 start (w1), 1 skip
  localparam logic [7:0] REG_HDR_ADDR = 8'h04; // Byte address of the header
  localparam logic [7:0] REG_STATUS = 8'h08;   // 0 busy, 1 done, 2 err, 6:4 runs
  localparam logic [7:0] REG_HDR0 = 8'h10;     // Copy of header word 0
  localparam logic [7:0] REG_HDR1 = 8'h14;     // Copy of header word 1
  localparam logic [7:0] REG_TBL = 8'h20;      // Table words 0..7 from here
  localparam logic [7:0] REG_TBL_END = 8'h3c;  // Last table word

  // ==========================================================================
  // State encodings
  // ==========================================================================
  typedef enum logic [2:0] {S_IDLE, S_XFER, S_WAIT, S_GAP, S_NEXT, S_SEL} ods_st_e;
  typedef enum logic [1:0] {P_HDR, P_TBL, P_SEQ} ods_ph_e;
  typedef enum logic [1:0] {B_IDLE, B_LOW, B_HIGH} ods_bit_e;

endpackage : ods_pkg

// ==== rtl/ods_spi_byte.sv ====
/*
  Byte shifter for single SPI, mode 0: eight SCK periods per byte, MSB first.
  Assumes chip select is handled by the caller and stays low meanwhile.
*/
`timescale 1ns/1ps
module ods_spi_byte
  import ods_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic start_i,          // One-cycle request for a byte
  input wire logic [7:0] tx_i,       // Byte to send
  input wire logic so_i,             // Serial data from the flash
  output logic sck_o,                // Serial clock, made here
  output logic si_o,                 // Serial data to the flash
  output logic done_o,               // Pulse with the eighth falling edge
  output logic [7:0] rx_o            // Byte received, valid with done_o
);
  import ods_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    ods_bit_e st;      // Phase of the current bit
    logic [1:0] div;   // Half period divider
    logic [2:0] bitc;  // Bit within the byte
    logic [7:0] sh;    // Shift register, out at top, in at bottom
    logic sck;
    logic si;
    logic done;
    logic syn1;        // First synchroniser stage
    logic syn2;        // Second synchroniser stage
  } ods_byte_s;

  ods_byte_s r;
  ods_byte_s next_r;
  logic tick;          // End of a half period

  // Next state: the divider only runs inside a byte, so SCK never free-runs
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.syn1 = so_i;
    next_r.syn2 = r.syn1;
    tick = (r.div == SCK_DIV_LAST);
    if (r.st != B_IDLE) begin
      next_r.div = tick ? 2'h0 : r.div + 2'h1;
    end
    unique case (r.st)
      B_IDLE: begin
        if (start_i) begin
          next_r.sh = tx_i;
          next_r.si = tx_i[7];
          next_r.bitc = 3'h0;
          next_r.div = 2'h0;
          next_r.st = B_LOW;
        end
      end
      B_LOW: begin
        // Data has stood a full half period before the rising edge
        if (tick) begin
          next_r.sck = 1'b1;
          next_r.st = B_HIGH;
        end
      end
      B_HIGH: begin
        // Sampling late in the high phase hides the synchroniser delay
        if (tick) begin
          next_r.sck = 1'b0;
          next_r.sh = {r.sh[6:0], r.syn2};
          if (r.bitc == 3'h7) begin
            next_r.done = 1'b1;
            next_r.st = B_IDLE;
          end else begin
            next_r.bitc = r.bitc + 3'h1;
            next_r.si = r.sh[6];
            next_r.st = B_LOW;
          end
        end
      end
    endcase
  end

  // Register the state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sck_o = r.sck;
  assign si_o = r.si;
  assign done_o = r.done;
  assign rx_o = r.sh;

endmodule : ods_spi_byte

// ==== rtl/ods_apb_regs.sv ====
/*
  APB slave holding the sequencer's control and status registers.
  Assumes APB without wait states; read data is captured in the setup cycle.
*/
`timescale 1ns/1ps
module ods_apb_regs
  import ods_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic busy_i,               // Sequencer is running
  input wire logic done_i,               // Last run finished
  input wire logic err_i,                // Last run found a bad table
  input wire logic [2:0] runs_i,         // Sequences sent in the last run
  input wire logic [1:0][31:0] hdr_i,    // Header words as read
  input wire logic [7:0][31:0] tbl_i,    // Table words as read
  output logic start_o,                  // One-cycle start pulse
  output logic skip_o,                   // Device already in the target mode
  output logic [23:0] hdr_addr_o         // Byte address of the header
);
  import ods_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic skip;
    logic [23:0] hdr_addr;
    logic start;
    logic [31:0] rdata;
  } ods_regs_s;

  ods_regs_s r;
  ods_regs_s next_r;
  logic setup;        // APB setup cycle
  logic wr;           // Write taking effect this edge
  logic in_tbl;       // Address inside the table window
  logic mapped;       // Address decodes to a register

  // Decode, write and read capture
  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    setup = psel_i && !penable_i;
    wr = psel_i && penable_i && pwrite_i;
    in_tbl = (paddr_i >= REG_TBL) && (paddr_i <= REG_TBL_END);
    mapped = (paddr_i[1:0] == 2'h0) && (in_tbl || paddr_i == REG_CTRL
      || paddr_i == REG_HDR_ADDR || paddr_i == REG_STATUS
      || paddr_i == REG_HDR0 || paddr_i == REG_HDR1);
    if (wr && mapped) begin
      if (paddr_i == REG_CTRL) begin
        next_r.skip = pwdata_i[1];
        // A start while busy is dropped rather than restarting a frame
        next_r.start = pwdata_i[0] && !busy_i;
      end else if (paddr_i == REG_HDR_ADDR) begin
        next_r.hdr_addr = pwdata_i[23:0];
      end
    end
    if (setup) begin
      next_r.rdata = 32'h0;
      if (in_tbl) begin
        next_r.rdata = tbl_i[paddr_i[4:2]];
      end else if (paddr_i == REG_CTRL) begin
        next_r.rdata = {30'h0, r.skip, 1'b0};
      end else if (paddr_i == REG_HDR_ADDR) begin
        next_r.rdata = {8'h0, r.hdr_addr};
      end else if (paddr_i == REG_STATUS) begin
        next_r.rdata = {25'h0, runs_i, 1'b0, err_i, done_i, busy_i};
      end else if (paddr_i == REG_HDR0) begin
        next_r.rdata = hdr_i[0];
      end else if (paddr_i == REG_HDR1) begin
        next_r.rdata = hdr_i[1];
      end
    end
  end

  // Register the state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata_o = r.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign start_o = r.start;
  assign skip_o = r.skip;
  assign hdr_addr_o = r.hdr_addr;

endmodule : ods_apb_regs

// ==== rtl/ods_sequencer.sv ====
/*
  Host side sequencer that reads the octal DDR switch table from a serial
  flash in single SPI mode and replays its command sequences.
  Assumes the flash answers the parameter read command with 8 dummy cycles,
  and that software has located the header and set its byte address.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Mode change is several separate command sequences
// - Each sequence: select low, bytes, select high
// - Two words per sequence: count, seven bytes
// - Zero count: no select, no clock
// - Unused byte slots are ignored
// - At most four sequences per change
// - Keep order; odd sequences enable writes
// - Exactly eight clocks per byte, nothing extra
// - Read the whole table before sequences
// - Skip sequences if already in target mode
// - Header length in bits 31:24, one-based
// - Missing trailing entries mean not implemented
// - Header identifier low byte is 0Ah
// - Major revision 23:16, minor revision 15:8
// - Second header word high byte FFh
// - Second word bits 23:0 give table_start_pointer
// - Count in 31-24, bytes follow descending
module ods_sequencer
  import ods_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic cs_n_o,               // Flash chip select, active low
  output logic sck_o,                // Flash serial clock
  output logic si_o,                 // Flash serial data in (IO0)
  input wire logic so_i,             // Flash serial data out (IO1)
  output logic busy_o                // Run in progress
);
  import ods_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    ods_st_e st;              // Frame level state
    ods_ph_e ph;              // Header read, table read or sequence
    logic cs_n;               // Chip select, registered
    logic bstart;             // Start pulse to the byte shifter
    logic [7:0] txb;          // Byte offered to the shifter
    logic [23:0] addr;        // Read address of the current frame
    logic [5:0] bidx;         // Byte within the frame
    logic [5:0] nbytes;       // Bytes in the frame
    logic [1:0] seq;          // Sequence being considered
    logic [1:0] gap;          // Chip select high counter
    logic busy;
    logic done;
    logic err;
    logic [2:0] runs;         // Sequences actually sent
    logic [1:0][31:0] hdr;    // Header words
    logic [7:0][31:0] tbl;    // Table words, zero where absent
  } ods_seq_s;

  ods_seq_s r;
  ods_seq_s next_r;

  // Shifter and register file links
  logic byte_done;
  logic [7:0] rx_byte;
  logic start;
  logic skip;
  logic [23:0] hdr_addr;

  // Combinational helpers, assigned at the top of the process
  logic [7:0] len;            // Table length in words
  logic [3:0] words;          // Words to fetch, capped at the table size
  logic [5:0] off;            // Data byte offset within a read frame
  logic [63:0] seqw;          // Both words of the current sequence
  logic [7:0] cnt;            // Byte count of the current sequence
  logic present;              // Sequence lies inside the table length
  logic last_seq;             // Fourth sequence reached

  // ==========================================================================
  // Sub blocks
  // ==========================================================================
  ods_spi_byte u_byte (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .start_i(r.bstart),
    .tx_i(r.txb),
    .so_i(so_i),
    .sck_o(sck_o),
    .si_o(si_o),
    .done_o(byte_done),
    .rx_o(rx_byte)
  );

  ods_apb_regs u_regs (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .busy_i(r.busy),
    .done_i(r.done),
    .err_i(r.err),
    .runs_i(r.runs),
    .hdr_i(r.hdr),
    .tbl_i(r.tbl),
    .start_o(start),
    .skip_o(skip),
    .hdr_addr_o(hdr_addr)
  );

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // One frame at a time; the shifter is the only source of SCK, so a frame
  // carries no clock beyond eight per byte of its count.
  always_comb begin
    next_r = r;
    next_r.bstart = 1'b0;
    len = r.hdr[0][LEN_MSB:LEN_LSB];
    words = (len > 8'(TBL_WORDS)) ? 4'(TBL_WORDS) : len[3:0];
    off = r.bidx - RD_PREFIX;
    seqw = {r.tbl[{r.seq, 1'b0}], r.tbl[{r.seq, 1'b1}]};
    cnt = seqw[63:56];
    present = {5'h0, r.seq, 1'b0} < len;
    last_seq = (r.seq == 2'h3);
    unique case (r.st)
      S_IDLE: begin
        if (start) begin
          next_r.done = 1'b0;
          next_r.err = 1'b0;
          next_r.runs = 3'h0;
          if (skip) begin
            // Software found the device already in the target mode
            next_r.done = 1'b1;
          end else begin
            next_r.busy = 1'b1;
            next_r.hdr = '0;
            next_r.tbl = '0;
            next_r.ph = P_HDR;
            next_r.addr = hdr_addr;
            next_r.nbytes = HDR_BYTES;
            next_r.bidx = 6'h0;
            next_r.cs_n = 1'b0;
            next_r.st = S_XFER;
          end
        end
      end
      S_XFER: begin
        // Pick the byte for this slot and hand it to the shifter
        if (r.ph == P_SEQ) begin
          next_r.txb = seqw[55 - 8 * int'(r.bidx) -: 8];
        end else if (r.bidx == 6'h0) begin
          next_r.txb = CMD_READ_TABLE;
        end else if (r.bidx == 6'h1) begin
          next_r.txb = r.addr[23:16];
        end else if (r.bidx == 6'h2) begin
          next_r.txb = r.addr[15:8];
        end else if (r.bidx == 6'h3) begin
          next_r.txb = r.addr[7:0];
        end else begin
          next_r.txb = 8'h00; // Dummy byte and read slots
        end
        next_r.bstart = 1'b1;
        next_r.st = S_WAIT;
      end
      S_WAIT: begin
        if (byte_done) begin
          // Read data arrives least significant byte of each word first
          if (r.ph == P_HDR && r.bidx >= RD_PREFIX) begin
            next_r.hdr[off[2]][8 * int'(off[1:0]) +: 8] = rx_byte;
          end else if (r.ph == P_TBL && r.bidx >= RD_PREFIX) begin
            next_r.tbl[off[4:2]][8 * int'(off[1:0]) +: 8] = rx_byte;
          end
          if (r.bidx == r.nbytes - 6'h1) begin
            next_r.cs_n = 1'b1;
            next_r.gap = 2'h0;
            next_r.st = S_GAP;
          end else begin
            next_r.bidx = r.bidx + 6'h1;
            next_r.st = S_XFER;
          end
        end
      end
      S_GAP: begin
        // Hold select high long enough for the device to close the frame
        if (r.gap == CS_GAP_LAST) begin
          next_r.st = S_NEXT;
        end else begin
          next_r.gap = r.gap + 2'h1;
        end
      end
      S_NEXT: begin
        unique case (r.ph)
          P_HDR: begin
            // Revision fields are kept for software, not checked here
            if (r.hdr[0][REV_MIN_LSB - 1:0] != ID_LSB
                || r.hdr[1][LEN_MSB:LEN_LSB] != ID_MSB
                || r.hdr[1][1:0] != 2'h0) begin
              next_r.err = 1'b1;
              next_r.done = 1'b1;
              next_r.busy = 1'b0;
              next_r.st = S_IDLE;
            end else if (len == 8'h0) begin
              next_r.done = 1'b1;
              next_r.busy = 1'b0;
              next_r.st = S_IDLE;
            end else begin
              // Whole table first: the switch changes how reads answer
              next_r.ph = P_TBL;
              next_r.addr = r.hdr[1][PTR_MSB:0];
              next_r.nbytes = RD_PREFIX + {words, 2'h0};
              next_r.bidx = 6'h0;
              next_r.cs_n = 1'b0;
              next_r.st = S_XFER;
            end
          end
          P_TBL: begin
            next_r.seq = 2'h0;
            next_r.st = S_SEL;
          end
          default: begin
            // A sequence frame has just closed
            next_r.runs = r.runs + 3'h1;
            if (last_seq) begin
              next_r.done = 1'b1;
              next_r.busy = 1'b0;
              next_r.st = S_IDLE;
            end else begin
              next_r.seq = r.seq + 2'h1;
              next_r.st = S_SEL;
            end
          end
        endcase
      end
      S_SEL: begin
        if (present && cnt > SEQ_MAX) begin
          // A count above seven cannot be sent in two words
          next_r.err = 1'b1;
          next_r.done = 1'b1;
          next_r.busy = 1'b0;
          next_r.st = S_IDLE;
        end else if (present && cnt != 8'h0) begin
          next_r.ph = P_SEQ;
          next_r.nbytes = cnt[5:0];
          next_r.bidx = 6'h0;
          next_r.cs_n = 1'b0;
          next_r.st = S_XFER;
        end else if (last_seq) begin
          // Empty or absent: no select, no clock for it
          next_r.done = 1'b1;
          next_r.busy = 1'b0;
          next_r.st = S_IDLE;
        end else begin
          next_r.seq = r.seq + 2'h1;
        end
      end
      default: begin
        next_r.st = S_IDLE;
      end
    endcase
  end

  // Register the state; select idles high after reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.cs_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign cs_n_o = r.cs_n;
  assign busy_o = r.busy;

endmodule : ods_sequencer

// ==== tb/ods_sequencer_monitor.sv ====
/* Checker for the sequencer ports: SPI framing, SCK timing, APB errors.
   Assumes a bind to ods_sequencer and one clock domain. */
`timescale 1ns/1ps
module ods_sequencer_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pslverr_o,
  input wire logic cs_n_o,
  input wire logic sck_o,
  input wire logic si_o,
  input wire logic busy_o
);
  // ==========================================================
  // Helper: SCK rising edges inside the current frame
  // ==========================================================
  logic sck_q; // SCK one cycle back
  logic [9:0] nbits; // Wide enough for the table read frame
  always_ff @(posedge clk_sys_i) begin
    sck_q <= sck_o;
    if (!rst_n_i || cs_n_o) begin
      nbits <= 10'h000;
    end else if (sck_o && !sck_q) begin
      nbits <= nbits + 10'h001;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Assertions
  // ==========================================================
  a_frame_whole_bytes: assert property (
    $rose(cs_n_o) |-> nbits[2:0] == 3'h0 && nbits != 10'h000) else $error("partial byte");
  a_cs_gap_min: assert property ($rose(cs_n_o) |=> cs_n_o [*2])
    else $error("select high too short");
  a_sck_idle_low: assert property (cs_n_o |-> !sck_o)
    else $error("clock outside frame");
  a_sck_high_two: assert property ($rose(sck_o) |=> sck_o ##1 !sck_o)
    else $error("clock high phase wrong");
  a_si_held_high: assert property (sck_o |-> $stable(si_o))
    else $error("data moved while clock high");
  a_frame_when_busy: assert property (!busy_o |-> cs_n_o)
    else $error("frame while idle");
  a_busy_ends_idle: assert property (
    $fell(busy_o) |-> cs_n_o && $past(cs_n_o) && $past(cs_n_o, 2)) else $error("early done");
  a_slverr_unaligned: assert property (psel_i && penable_i && paddr_i[1:0] != 2'h0 |-> pslverr_o)
    else $error("unaligned access accepted");
  // Main scenarios reached
  cover property ($rose(cs_n_o));
  cover property ($fell(busy_o));
  cover property (pslverr_o);
endmodule : ods_sequencer_monitor

// ==== tb/ods_flash_model.sv ====
/* Behavioural serial flash: answers the parameter read from a byte memory
   and logs each frame's bytes and clock count. Assumes SPI mode 0. */
`timescale 1ns/1ps
module ods_flash_model (
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o
);
  logic [7:0] mem [0:255]; // Parameter space, set by the bench
  logic [7:0] fb [$]; // All bytes received, in order
  int fbits [$]; // Clock count of every frame, judged later
  int nb = 0; // Clocks in this frame
  logic [7:0] sr; // Shift register
  logic [7:0] cmd; // First byte of the frame
  logic [7:0] dout; // Byte being sent
  logic [23:0] addr; // Read pointer
  initial so_o = 1'b0;
  // Frame start
  always @(negedge cs_n_i) begin
    nb = 0;
    cmd = 8'h00;
  end
  // Frame end: log count; IO1 released, so it flips rather than holding
  always @(posedge cs_n_i) begin
    fbits.push_back(nb);
    so_o = ~so_o;
  end
  // Capture on rising SCK, MSB first
  always @(posedge sck_i) begin
    if (!cs_n_i) begin
      sr = {sr[6:0], si_i};
      nb++;
      if (nb % 8 == 0) fb.push_back(sr);
      if (nb == 8) cmd = sr;
      if (nb > 8 && nb <= 32 && nb % 8 == 0) addr = {addr[15:0], sr};
    end
  end
  // Read data leaves on falling SCK once the dummy byte has passed
  always @(negedge sck_i) begin
    if (!cs_n_i && cmd == ods_pkg::CMD_READ_TABLE && nb >= 40) begin
      if (nb % 8 == 0) begin
        dout = mem[addr[7:0]];
        addr++;
      end
      so_o = dout[7 - nb % 8];
    end
  end
endmodule : ods_flash_model

// ==== tb/octal_ddr_switch_sequencer_tb_top.sv ====
/* Top bench: APB driver, flash model, table rows, then awkward cases.
   Assumes the checker and flash model compile first. */
`timescale 1ns/1ps
module octal_ddr_switch_sequencer_tb_top;
  import ods_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, cs_n_o, sck_o, si_o, so_i, busy_o, er;
  int fails = 0, num_checks = 0, p, f;
  typedef struct {int len; int cnt[4]; int runs;} ods_row_s; // Table length, counts
  ods_row_s rows[3] = '{'{8, '{1, 3, 1, 7}, 4}, '{4, '{2, 7, 5, 5}, 2}, '{8, '{0, 2, 0, 6}, 2}};
  ods_sequencer ods_sequencer_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .cs_n_o(cs_n_o), .sck_o(sck_o), .si_o(si_o), .so_i(so_i), .busy_o(busy_o));
  ods_flash_model ods_flash_model_inst (.cs_n_i(cs_n_o), .sck_i(sck_o), .si_i(si_o),
    .so_o(so_i));
  initial forever #10 clk_sys_i = ~clk_sys_i;
  // ==========================================================
  // Tasks
  // ==========================================================
  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Header at 10h pointing at a table at 30h; unused slots hold nonzero junk
  task automatic load(input ods_row_s r, input logic [7:0] id);
    ods_flash_model_inst.mem[8'h10] = id;
    ods_flash_model_inst.mem[8'h11] = 8'h00;
    ods_flash_model_inst.mem[8'h12] = 8'h01;
    ods_flash_model_inst.mem[8'h13] = 8'(r.len);
    ods_flash_model_inst.mem[8'h14] = 8'h30;
    ods_flash_model_inst.mem[8'h15] = 8'h00;
    ods_flash_model_inst.mem[8'h16] = 8'h00;
    ods_flash_model_inst.mem[8'h17] = ID_MSB;
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 8; k++) begin
        ods_flash_model_inst.mem[8'(48 + 8 * s + (k < 4 ? 3 - k : 11 - k))] =
          k ? 8'(64 + 16 * s + k) : 8'(r.cnt[s]);
      end
    end
    ods_flash_model_inst.fb.delete();
    ods_flash_model_inst.fbits.delete();
  endtask : load
  task automatic run(input logic [31:0] ctrl);
    apb(1, REG_HDR_ADDR, 32'h10, rd, er);
    apb(1, REG_CTRL, ctrl, rd, er);
    repeat (4) @(posedge clk_sys_i);
    for (int i = 0; i < 20000 && busy_o !== 1'b0; i++) @(posedge clk_sys_i);
    if (busy_o !== 1'b0) fails++;
    apb(0, REG_STATUS, 32'h0, rd, er);
  endtask : run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1;
    chk("cs_n idle", 1, cs_n_o);
    apb(0, REG_STATUS, 32'h0, rd, er);
    chk("status reset", 0, rd);
    foreach (rows[i]) begin
      load(rows[i], ID_LSB);
      run(1);
      chk("status", 32'h2 | rows[i].runs << 4, rd);
      chk("frames", 2 + rows[i].runs, ods_flash_model_inst.fbits.size());
      chk("hdr bits", 104, ods_flash_model_inst.fbits[0]);
      chk("tbl bits", 8 * (5 + 4 * rows[i].len), ods_flash_model_inst.fbits[1]);
      p = 18 + 4 * rows[i].len;
      f = 2;
      for (int s = 0; s < 4; s++) begin
        if (2 * s < rows[i].len && rows[i].cnt[s] != 0) begin // Empty or absent: no frame
          chk("seq bits", 8 * rows[i].cnt[s], ods_flash_model_inst.fbits[f]);
          for (int k = 1; k <= rows[i].cnt[s]; k++) begin
            chk("seq byte", 64 + 16 * s + k, ods_flash_model_inst.fb[p + k - 1]);
          end
          p += rows[i].cnt[s];
          f++;
        end
      end
    end
    load(rows[0], 8'h0b);
    run(1);
    chk("bad id err", 1, rd[2]);
    chk("bad id frames", 1, ods_flash_model_inst.fbits.size());
    load(rows[0], ID_LSB);
    run(3);
    chk("skip status", 2, rd);
    chk("skip frames", 0, ods_flash_model_inst.fbits.size());
    apb(0, 8'h0e, 32'h0, rd, er);
    chk("unaligned err", 1, er);
    chk("unaligned data", 0, rd);
    close_out();
  end
  // Cuts a hang short
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    fails++;
    close_out();
  end
endmodule : octal_ddr_switch_sequencer_tb_top
bind ods_sequencer ods_sequencer_monitor ods_sequencer_monitor_inst (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
  .pslverr_o(pslverr_o), .cs_n_o(cs_n_o), .sck_o(sck_o), .si_o(si_o), .busy_o(busy_o));
